// file: rtl/pllis_top.sv
// PLL input select, gating and charge pump output control with APB registers
//
// Overview of operation
// - With FM chosen the FM oscillator feeds the divider and the two band bits are ignored.
// - With AM chosen, band bits 1,0 pick short wave and 1,1 pick medium and long wave.
// - Both oscillator inputs are blocked while hold mode is enabled and the hold pin is low.
// - Both oscillator inputs are blocked in clock stop, during power-on reset and with the PLL stopped.
// - Dead zone code 00 floats the sub pump and code 11 runs it whenever the main pumps drive.
// - Codes 01 and 10 run the sub pump only when unlocked, at the 450 kHz or 900 kHz setting.
// - The second pump drives low when the divided oscillator is higher and high when lower.
// - The second pump floats when the divided oscillator matches the reference.
// - The second pump floats while hold mode is enabled and the hold pin is low.
// - The second pump floats in clock stop, during power-on reset and with the PLL stopped.
// - The main pumps drive high when higher, low when lower and float when matched.
`timescale 1ns/1ps
`default_nettype none
module pllis_top
	import pllis_pkg::*;
(
	input wire logic pclk, // System clock, 10 MHz
	input wire logic presetn, // Async reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [7:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	input wire logic [3:0] pstrb, // APB byte strobes
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error, unmapped address
	input wire logic fm_lo_input, // FM local oscillator
	input wire logic am_lo_input, // AM local oscillator
	input wire logic hold_pin_n, // Hold pin, active low
	input wire logic power_on_reset, // Power-on reset in progress
	input wire logic divided_lo, // Divider output
	input wire logic ref_pulse, // Reference clock
	input wire logic unlock, // Unlock detector flag
	output logic divider_input, // Selected oscillator to divider
	output logic am_band_mw, // AM band is medium/long wave
	output logic main_pump_output_a, // Main pump A level
	output logic main_pump_output_a_oe, // Main pump A drive enable
	output logic main_pump_output_b, // Main pump B level
	output logic main_pump_output_b_oe, // Main pump B drive enable
	output logic second_pump_output, // Second pump level
	output logic second_pump_output_oe, // Second pump drive enable
	output logic sub_pump_output, // Sub pump level
	output logic sub_pump_output_oe, // Sub pump drive enable
	output logic sub_pump_rate_900 // Sub pump 900 kHz setting
);
	// State of the block apart from the comparator direction held in u_cmp
	typedef struct packed {
		logic [2:0] band_select_code;
		logic [1:0] dead_zone_control_cmd;
		logic [2:0] mode;
		logic div_last;
		logic ref_last;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic divider_input;
		logic am_band_mw;
		logic main_a;
		logic main_a_oe;
		logic main_b;
		logic main_b_oe;
		logic second;
		logic second_oe;
		logic sub;
		logic sub_oe;
		logic sub_900;
	} pllis_state_t;

	localparam pllis_state_t PLLIS_STATE_RST = '{
		band_select_code: PLLIS_BAND_RST,
		dead_zone_control_cmd: PLLIS_DZC_RST,
		mode: PLLIS_MODE_RST,
		div_last: 1'b0,
		ref_last: 1'b0,
		prdata: 32'h00000000,
		pready: 1'b0,
		pslverr: 1'b0,
		divider_input: 1'b0,
		am_band_mw: 1'b0,
		main_a: 1'b0,
		main_a_oe: 1'b0,
		main_b: 1'b0,
		main_b_oe: 1'b0,
		second: 1'b0,
		second_oe: 1'b0,
		sub: 1'b0,
		sub_oe: 1'b0,
		sub_900: 1'b0
	};

	pllis_state_t cur;
	pllis_state_t next_state;

	logic blocked;
	logic hold_block;
	logic stop_block;
	logic div_edge;
	logic ref_edge;
	logic feed;
	logic sel_fm;
	logic sel_am;
	pllis_cmp_t cmp;

	// Rising edge of a sampled level
	function automatic logic pllis_rise(input logic now, input logic last);
		pllis_rise = now & ~last;
	endfunction

	// Address decode shared by the read and write paths
	function automatic logic pllis_mapped(input logic [7:0] addr);
		pllis_mapped = (addr == PLLIS_BAND_OFS) || (addr == PLLIS_DZC_OFS) ||
			(addr == PLLIS_MODE_OFS) || (addr == PLLIS_STATUS_OFS);
	endfunction

	assign hold_block = cur.mode[PLLIS_MODE_HOLD_EN_BIT] & ~hold_pin_n;
	assign stop_block = cur.mode[PLLIS_MODE_CLK_STOP_BIT] | cur.mode[PLLIS_MODE_PLL_STOP_BIT] | power_on_reset;
	assign blocked = hold_block | stop_block;

	assign div_edge = pllis_rise(divided_lo, cur.div_last);
	assign ref_edge = pllis_rise(ref_pulse, cur.ref_last);

	// Input selection and gating toward the divider
	pllis_lo_gate u_gate (
		.band_select_code(cur.band_select_code),
		.fm_lo_input(fm_lo_input),
		.am_lo_input(am_lo_input),
		.blocked(blocked),
		.divider_feed(feed),
		.sel_fm(sel_fm),
		.sel_am(sel_am)
	);

	// Comparator is held at equal while blocked so stale direction never resumes
	pllis_phase_cmp u_cmp (
		.pclk(pclk),
		.presetn(presetn),
		.clear(blocked),
		.div_edge(div_edge),
		.ref_edge(ref_edge),
		.cmp(cmp)
	);

	// Next state of registers, bus and pump outputs
	always_comb begin
		logic higher;
		logic lower;
		logic drive;
		logic sub_run;
		logic [31:0] rd;
		next_state = cur;
		higher = (cmp == PLLIS_CMP_HIGHER);
		lower = (cmp == PLLIS_CMP_LOWER);
		drive = 1'b0;
		sub_run = 1'b0;
		rd = 32'h00000000;

		// Edge history for the comparator
		next_state.div_last = divided_lo;
		next_state.ref_last = ref_pulse;

		// APB answer: ready comes one cycle after setup, data fixed then
		next_state.pready = psel & ~penable;
		next_state.pslverr = psel & ~penable & ~pllis_mapped(paddr);
		if (psel && !penable) begin
			unique case (paddr)
				PLLIS_BAND_OFS: rd[2:0] = cur.band_select_code;
				PLLIS_DZC_OFS: begin
					rd[PLLIS_DZC_B3_BIT] = cur.dead_zone_control_cmd[1];
					rd[PLLIS_DZC_B2_BIT] = cur.dead_zone_control_cmd[0];
				end
				PLLIS_MODE_OFS: rd[2:0] = cur.mode;
				PLLIS_STATUS_OFS: begin
					rd[PLLIS_ST_HIGHER_BIT] = higher;
					rd[PLLIS_ST_LOWER_BIT] = lower;
					rd[PLLIS_ST_UNLOCK_BIT] = unlock;
					rd[PLLIS_ST_BLOCKED_BIT] = blocked;
					rd[PLLIS_ST_SUB_ACT_BIT] = cur.sub_oe;
					rd[PLLIS_ST_SRC_FM_BIT] = sel_fm;
					rd[PLLIS_ST_SRC_AM_BIT] = sel_am;
				end
				default: rd = 32'h00000000;
			endcase
			next_state.prdata = rd;
		end

		// Write commits at the access edge where ready is high; low lane only
		if (psel && penable && cur.pready && pwrite && pstrb[0] && !cur.pslverr) begin
			unique case (paddr)
				PLLIS_BAND_OFS: next_state.band_select_code = pwdata[2:0];
				PLLIS_DZC_OFS: begin
					next_state.dead_zone_control_cmd = {pwdata[PLLIS_DZC_B3_BIT], pwdata[PLLIS_DZC_B2_BIT]};
				end
				PLLIS_MODE_OFS: next_state.mode = pwdata[2:0];
				default: next_state.mode = cur.mode;
			endcase
		end

		next_state.divider_input = feed;
		next_state.am_band_mw = sel_am & cur.band_select_code[PLLIS_BAND_B0_BIT];

		// drive only with a direction and no gate
		drive = (higher | lower) & ~blocked;

		next_state.main_a = higher;
		next_state.main_b = higher;
		next_state.main_a_oe = drive;
		next_state.main_b_oe = drive;

		next_state.second = lower;
		next_state.second_oe = drive;

		unique case (cur.dead_zone_control_cmd)
			PLLIS_DZ_OFF: sub_run = 1'b0;
			PLLIS_DZ_UNL_450: sub_run = unlock;
			PLLIS_DZ_UNL_900: sub_run = unlock;
			PLLIS_DZ_NORMAL: sub_run = 1'b1;
		endcase
		// Sub pump follows main polarity, also silenced by the input gate
		next_state.sub = higher;
		next_state.sub_oe = sub_run & drive;
		next_state.sub_900 = (cur.dead_zone_control_cmd == PLLIS_DZ_UNL_900);
	end

	// Single state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cur <= PLLIS_STATE_RST;
		end else begin
			cur <= next_state;
		end
	end

	// Outputs straight from the state flops
	assign prdata = cur.prdata;
	assign pready = cur.pready;
	assign pslverr = cur.pslverr;
	assign divider_input = cur.divider_input;
	assign am_band_mw = cur.am_band_mw;
	assign main_pump_output_a = cur.main_a;
	assign main_pump_output_a_oe = cur.main_a_oe;
	assign main_pump_output_b = cur.main_b;
	assign main_pump_output_b_oe = cur.main_b_oe;
	assign second_pump_output = cur.second;
	assign second_pump_output_oe = cur.second_oe;
	assign sub_pump_output = cur.sub;
	assign sub_pump_output_oe = cur.sub_oe;
	assign sub_pump_rate_900 = cur.sub_900;
endmodule
`default_nettype wire

// file: rtl/pllis_pkg.sv
// Package of offsets, field positions and reset values for the PLL input select block
package pllis_pkg;
	// APB register byte offsets
	localparam logic [7:0] PLLIS_BAND_OFS = 8'h00;
	localparam logic [7:0] PLLIS_DZC_OFS = 8'h04;
	localparam logic [7:0] PLLIS_MODE_OFS = 8'h08;
	localparam logic [7:0] PLLIS_STATUS_OFS = 8'h0c;
	// Band select field positions
	localparam int PLLIS_BAND_AM_BIT = 2;
	localparam int PLLIS_BAND_B1_BIT = 1;
	localparam int PLLIS_BAND_B0_BIT = 0;
	// Dead zone field positions (b3, b2)
	localparam int PLLIS_DZC_B3_BIT = 3;
	localparam int PLLIS_DZC_B2_BIT = 2;
	// Mode register field positions
	localparam int PLLIS_MODE_HOLD_EN_BIT = 0;
	localparam int PLLIS_MODE_CLK_STOP_BIT = 1;
	localparam int PLLIS_MODE_PLL_STOP_BIT = 2;
	// Status register field positions
	localparam int PLLIS_ST_HIGHER_BIT = 0;
	localparam int PLLIS_ST_LOWER_BIT = 1;
	localparam int PLLIS_ST_UNLOCK_BIT = 2;
	localparam int PLLIS_ST_BLOCKED_BIT = 3;
	localparam int PLLIS_ST_SUB_ACT_BIT = 4;
	localparam int PLLIS_ST_SRC_FM_BIT = 5;
	localparam int PLLIS_ST_SRC_AM_BIT = 6;
	// Reset values
	localparam logic [2:0] PLLIS_BAND_RST = 3'h0;
	localparam logic [1:0] PLLIS_DZC_RST = 2'h0;
	localparam logic [2:0] PLLIS_MODE_RST = 3'h4;
	// AM band codes on b1,b0
	localparam logic [1:0] PLLIS_AM_SW = 2'h2;
	localparam logic [1:0] PLLIS_AM_MW = 2'h3;
	// Dead zone codes on b3,b2
	localparam logic [1:0] PLLIS_DZ_OFF = 2'h0;
	localparam logic [1:0] PLLIS_DZ_UNL_450 = 2'h1;
	localparam logic [1:0] PLLIS_DZ_UNL_900 = 2'h2;
	localparam logic [1:0] PLLIS_DZ_NORMAL = 2'h3;
	// Comparator states
	typedef enum logic [1:0] {
		PLLIS_CMP_EQUAL = 2'b00,
		PLLIS_CMP_HIGHER = 2'b01,
		PLLIS_CMP_LOWER = 2'b10
	} pllis_cmp_t;
endpackage

// file: rtl/pllis_lo_gate.sv
// Local oscillator input selector and gate feeding the divider
`timescale 1ns/1ps
`default_nettype none
module pllis_lo_gate
	import pllis_pkg::*;
(
	input wire logic [2:0] band_select_code, // AM flag and b1,b0
	input wire logic fm_lo_input, // FM oscillator level
	input wire logic am_lo_input, // AM oscillator level
	input wire logic blocked, // Inputs disabled
	output logic divider_feed, // Selected oscillator
	output logic sel_fm, // FM path open
	output logic sel_am // AM path open
);
	logic [1:0] am_band;

	// Band bits only matter on the AM path
	assign am_band = {band_select_code[PLLIS_BAND_B1_BIT], band_select_code[PLLIS_BAND_B0_BIT]};

	// Path choice and gating
	always_comb begin
		sel_fm = 1'b0;
		sel_am = 1'b0;
		if (!blocked) begin
			if (!band_select_code[PLLIS_BAND_AM_BIT]) begin
				sel_fm = 1'b1;
			end else if (am_band == PLLIS_AM_SW || am_band == PLLIS_AM_MW) begin
				sel_am = 1'b1;
			end
		end
		divider_feed = (sel_fm & fm_lo_input) | (sel_am & am_lo_input);
	end
endmodule
`default_nettype wire

// file: rtl/pllis_phase_cmp.sv
// Phase frequency comparator of divided oscillator against reference
`timescale 1ns/1ps
`default_nettype none
module pllis_phase_cmp
	import pllis_pkg::*;
(
	input wire logic pclk, // System clock
	input wire logic presetn, // Async reset, active low
	input wire logic clear, // Force equal state
	input wire logic div_edge, // Divided oscillator rising edge
	input wire logic ref_edge, // Reference rising edge
	output pllis_cmp_t cmp // Higher, lower or equal
);
	typedef struct packed {
		pllis_cmp_t cmp;
	} pllis_pc_state_t;

	pllis_pc_state_t cur;
	pllis_pc_state_t nxt;

	always_comb begin
		nxt = cur;
		if (clear) begin
			nxt.cmp = PLLIS_CMP_EQUAL;
		end else if (div_edge && !ref_edge) begin
			unique case (cur.cmp)
				PLLIS_CMP_LOWER: nxt.cmp = PLLIS_CMP_EQUAL;
				PLLIS_CMP_EQUAL: nxt.cmp = PLLIS_CMP_HIGHER;
				PLLIS_CMP_HIGHER: nxt.cmp = PLLIS_CMP_HIGHER;
				default: nxt.cmp = PLLIS_CMP_EQUAL;
			endcase
		end else if (ref_edge && !div_edge) begin
			unique case (cur.cmp)
				PLLIS_CMP_HIGHER: nxt.cmp = PLLIS_CMP_EQUAL;
				PLLIS_CMP_EQUAL: nxt.cmp = PLLIS_CMP_LOWER;
				PLLIS_CMP_LOWER: nxt.cmp = PLLIS_CMP_LOWER;
				default: nxt.cmp = PLLIS_CMP_EQUAL;
			endcase
		end
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cur <= '{cmp: PLLIS_CMP_EQUAL};
		end else begin
			cur <= nxt;
		end
	end

	assign cmp = cur.cmp;
endmodule
`default_nettype wire

// file: sim/pllis_top_asserts.sv
// Port level checker for the PLL input select top
`timescale 1ns/1ps
`default_nettype none
module pllis_top_asserts
	import pllis_pkg::*;
(
	input wire logic pclk, // Clock
	input wire logic presetn, // Reset, active low
	input wire logic psel, // Select
	input wire logic penable, // Enable
	input wire logic pwrite, // Direction
	input wire logic [7:0] paddr, // Address
	input wire logic [31:0] pwdata, // Write data
	input wire logic [3:0] pstrb, // Strobes
	input wire logic pready, // Ready
	input wire logic hold_pin_n, // Hold pin
	input wire logic power_on_reset, // Power-on reset
	input wire logic unlock, // Unlocked
	input wire logic divider_input, // Divider feed
	input wire logic main_pump_output_a, // Main A
	input wire logic main_pump_output_a_oe, // Main A drive
	input wire logic main_pump_output_b, // Main B
	input wire logic main_pump_output_b_oe, // Main B drive
	input wire logic second_pump_output, // Second
	input wire logic second_pump_output_oe, // Second drive
	input wire logic sub_pump_output, // Sub
	input wire logic sub_pump_output_oe, // Sub drive
	input wire logic sub_pump_rate_900 // Sub rate
);
	logic [1:0] dz_m;
	logic [2:0] mode_m;
	logic wr_ok;
	// Committed write; registers are hidden, so they are mirrored
	assign wr_ok = psel && penable && pready && pwrite && pstrb[0];
	// Mirror of dead zone code and mode bits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dz_m <= PLLIS_DZC_RST;
			mode_m <= PLLIS_MODE_RST;
		end else if (wr_ok && paddr == PLLIS_DZC_OFS) begin
			dz_m <= pwdata[3:2];
		end else if (wr_ok && paddr == PLLIS_MODE_OFS) begin
			mode_m <= pwdata[2:0];
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_second_inverse: assert property (second_pump_output_oe |->
		second_pump_output != main_pump_output_a && main_pump_output_b == main_pump_output_a)
		else $error("second pump polarity wrong");
	a_float_match: assert property (second_pump_output_oe == main_pump_output_a_oe &&
		main_pump_output_b_oe == main_pump_output_a_oe) else $error("pump drive enables differ");
	a_por_block: assert property (power_on_reset |=>
		!divider_input && !second_pump_output_oe) else $error("output live in power-on reset");
	a_hold_block: assert property (mode_m[0] && !hold_pin_n |=> !divider_input &&
		!second_pump_output_oe && !main_pump_output_a_oe) else $error("output live in hold");
	a_stop_block: assert property ((mode_m[1] || mode_m[2]) |=> !divider_input &&
		!second_pump_output_oe) else $error("output live in stop");
	a_sub_off: assert property ($past(dz_m) == PLLIS_DZ_OFF |-> !sub_pump_output_oe)
		else $error("sub pump driven with code 00");
	a_sub_normal: assert property ($past(dz_m) == PLLIS_DZ_NORMAL |->
		sub_pump_output_oe == main_pump_output_a_oe && (!sub_pump_output_oe ||
		sub_pump_output == main_pump_output_a)) else $error("sub pump not in normal run");
	a_sub_unlock: assert property ((($past(dz_m) == PLLIS_DZ_UNL_450) ||
		($past(dz_m) == PLLIS_DZ_UNL_900)) && sub_pump_output_oe |-> $past(unlock) &&
		sub_pump_rate_900 == ($past(dz_m) == PLLIS_DZ_UNL_900)) else $error("sub pump unlock mode wrong");
	c_sub: cover property (sub_pump_output_oe && sub_pump_rate_900);
	c_lower: cover property (second_pump_output_oe && second_pump_output);
	c_hold: cover property (mode_m[0] && !hold_pin_n);
endmodule
bind pllis_top pllis_top_asserts u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
	.pready, .hold_pin_n, .power_on_reset, .unlock, .divider_input, .main_pump_output_a,
	.main_pump_output_a_oe, .main_pump_output_b, .main_pump_output_b_oe, .second_pump_output,
	.second_pump_output_oe, .sub_pump_output, .sub_pump_output_oe, .sub_pump_rate_900);
`default_nettype wire

// file: sim/pllis_vco_model.sv
// Oscillator and divider edge model on the far side
`timescale 1ns/1ps
`default_nettype none
module pllis_vco_model (
	input wire logic pclk, // Clock
	input wire logic presetn, // Reset, active low
	input wire logic div_req, // Ask a divider edge
	input wire logic ref_req, // Ask a reference edge
	output logic fm_lo_input, // FM oscillator
	output logic am_lo_input, // AM oscillator
	output logic divided_lo, // Divider level
	output logic ref_pulse // Reference level
);
	logic [1:0] phase;
	// Oscillators at different rates so a wrong route shows
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase <= 2'h0;
			divided_lo <= 1'h0;
			ref_pulse <= 1'h0;
		end else begin
			phase <= phase + 2'h1;
			divided_lo <= div_req;
			ref_pulse <= ref_req;
		end
	end
	assign fm_lo_input = phase[0];
	assign am_lo_input = phase[1];
endmodule
`default_nettype wire

// file: sim/testbench.sv
// Self-checking bench for the PLL input select top
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import pllis_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, hold_pin_n, power_on_reset, unlock;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rdv;
	logic [3:0] pstrb;
	logic div_req, ref_req, fm_lo_input, am_lo_input, divided_lo, ref_pulse, divider_input, am_band_mw, err;
	logic main_pump_output_a, main_pump_output_a_oe, main_pump_output_b, main_pump_output_b_oe;
	logic second_pump_output, second_pump_output_oe, sub_pump_output, sub_pump_output_oe, sub_pump_rate_900;
	int miscompares = 0;
	int check_count = 0;
	pllis_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
		.pslverr, .fm_lo_input, .am_lo_input, .hold_pin_n, .power_on_reset, .divided_lo, .ref_pulse, .unlock,
		.divider_input, .am_band_mw, .main_pump_output_a, .main_pump_output_a_oe, .main_pump_output_b,
		.main_pump_output_b_oe, .second_pump_output, .second_pump_output_oe, .sub_pump_output,
		.sub_pump_output_oe, .sub_pump_rate_900);
	pllis_vco_model partner (.pclk, .presetn, .div_req, .ref_req, .fm_lo_input, .am_lo_input,
		.divided_lo, .ref_pulse);
	// 100 ns period
	initial begin
		pclk = 1'h0;
		forever #50 pclk = ~pclk;
	end
	task print_verdict;
		$display("comparisons %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// One APB transfer; the wait is bounded so a silent slave cannot hang
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= 4'hf;
		@(posedge pclk);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'h1 && n < 20);
		rdv = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		if (pready !== 1'h1) begin
			miscompares++;
			print_verdict;
		end
	endtask
	// Divider edge when is_div, else a reference edge
	task pulse(input logic is_div);
		@(posedge pclk);
		div_req <= is_div;
		ref_req <= !is_div;
		@(posedge pclk);
		div_req <= 1'h0;
		ref_req <= 1'h0;
		repeat (4) @(posedge pclk);
	endtask
	// State 0 equal, 1 higher, 2 lower; levels masked while floating
	task pumps(input logic [1:0] st);
		@(negedge pclk);
		check("main_a", {main_pump_output_a_oe, main_pump_output_a & main_pump_output_a_oe}, {st != 2'h0, st == 2'h1});
		check("main_b", {main_pump_output_b_oe, main_pump_output_b & main_pump_output_b_oe}, {st != 2'h0, st == 2'h1});
		check("second", {second_pump_output_oe, second_pump_output & second_pump_output_oe}, {st != 2'h0, st == 2'h2});
	endtask
	task s_reset;
		apb(1'h0, PLLIS_BAND_OFS, 32'h0);
		check("band_rst", rdv, 32'h0);
		apb(1'h0, PLLIS_DZC_OFS, 32'h0);
		check("dzc_rst", rdv, 32'h0);
		apb(1'h0, PLLIS_MODE_OFS, 32'h0);
		check("mode_rst", rdv, 32'h4);
		apb(1'h0, 8'h10, 32'h0);
		check("unmapped", {err, rdv[30:0]}, 32'h80000000);
		check("div_stopped", divider_input, 1'h0);
		pumps(2'h0);
	endtask
	task s_routing;
		logic f, a;
		apb(1'h1, PLLIS_MODE_OFS, 32'h0);
		for (int b = 0; b < 8; b++) begin
			apb(1'h1, PLLIS_BAND_OFS, b);
			repeat (6) begin
				@(negedge pclk);
				f = fm_lo_input;
				a = am_lo_input;
				@(negedge pclk);
				check("divider_input", divider_input, b[2] ? (b[1] & a) : f);
				check("am_band_mw", am_band_mw, b == 7);
			end
		end
	endtask
	task s_compare;
		pulse(1'h1);
		pumps(2'h1);
		pulse(1'h0);
		pumps(2'h0);
		pulse(1'h0);
		pumps(2'h2);
		pulse(1'h1);
		pumps(2'h0);
	endtask
	task s_sub;
		logic e;
		pulse(1'h1);
		for (int c = 0; c < 4; c++) begin
			for (int u = 0; u < 2; u++) begin
				@(posedge pclk);
				unlock <= u;
				apb(1'h1, PLLIS_DZC_OFS, c << 2);
				repeat (3) @(negedge pclk);
				e = (c == 3) || (u == 1 && (c == 1 || c == 2));
				check("sub_pump", {sub_pump_output_oe, sub_pump_rate_900 & e, sub_pump_output & e}, {e, e && c == 2, e});
			end
		end
		pulse(1'h0);
	endtask
	// Hold, clock stop, PLL stop, power-on reset, then hold pin low without hold enabled
	task s_block;
		for (int i = 0; i < 5; i++) begin
			pulse(1'h1);
			@(posedge pclk);
			hold_pin_n <= !(i == 0 || i == 4);
			power_on_reset <= (i == 3);
			apb(1'h1, PLLIS_MODE_OFS, (i == 0) ? 32'h1 : (i == 1) ? 32'h2 : (i == 2) ? 32'h4 : 32'h0);
			// Gate reaches the divider flop one edge after the mode write lands
			@(negedge pclk);
			repeat (3) begin
				@(negedge pclk);
				check("div_blocked", divider_input & (i != 4), 1'h0);
			end
			pumps((i == 4) ? 2'h1 : 2'h0);
			@(posedge pclk);
			hold_pin_n <= 1'h1;
			power_on_reset <= 1'h0;
			apb(1'h1, PLLIS_MODE_OFS, 32'h0);
			if (i == 4) pulse(1'h0);
			pumps(2'h0);
		end
	endtask
	initial begin
		presetn = 1'h0;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 8'h0;
		pwdata = 32'h0;
		pstrb = 4'h0;
		hold_pin_n = 1'h1;
		power_on_reset = 1'h0;
		unlock = 1'h0;
		div_req = 1'h0;
		ref_req = 1'h0;
		repeat (10) @(posedge pclk);
		presetn <= 1'h1;
		s_reset;
		s_routing;
		s_compare;
		s_sub;
		s_block;
		print_verdict;
	end
endmodule
`default_nettype wire
